/* rtl/ssi_pkg.sv */
// Shared constants and carrier types for the serial status and interrupt bank.
// Assumes a 32-bit APB register port and one peripheral clock domain.
package ssi_pkg;

  // Register byte offsets on the APB port
  localparam logic [11:0] OFF_STATUS    = 12'h000;
  localparam logic [11:0] OFF_IRQ_SET   = 12'h004;
  localparam logic [11:0] OFF_IRQ_CLEAR = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h00C;
  localparam logic [11:0] OFF_EVT_CLEAR = 12'h010;

  // Widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned SRC_W  = 12;
  localparam int unsigned CNT_W  = 16;

  // Status bit positions
  localparam int unsigned BIT_TX_READY    = 0;
  localparam int unsigned BIT_TX_IDLE     = 1;
  localparam int unsigned BIT_TX_DMA_DONE = 2;
  localparam int unsigned BIT_TX_BUF_EMPT = 3;
  localparam int unsigned BIT_RX_READY    = 4;
  localparam int unsigned BIT_RX_OVERRUN  = 5;
  localparam int unsigned BIT_RX_DMA_DONE = 6;
  localparam int unsigned BIT_RX_BUF_FULL = 7;
  localparam int unsigned BIT_CMP_A       = 8;
  localparam int unsigned BIT_CMP_B       = 9;
  localparam int unsigned BIT_TX_SYNC     = 10;
  localparam int unsigned BIT_RX_SYNC     = 11;
  localparam int unsigned BIT_TX_ENABLED  = 16;
  localparam int unsigned BIT_RX_ENABLED  = 17;

  // Reset values and bit groups
  localparam logic [11:0] MASK_RESET      = 12'h000;
  localparam logic [11:0] STICKY_BITS     = 12'hF64;
  localparam logic [11:0] READ_CLEAR_BITS = 12'hF20;
  localparam logic [31:0] DATA_ZERO       = 32'h0000_0000;

  // Single-cycle events from the compare and frame-sync logic
  typedef struct packed {
    logic rx_sync;
    logic tx_sync;
    logic cmp_b;
    logic cmp_a;
  } ssi_events_s;

  // Current and next counter of one DMA direction
  typedef struct packed {
    logic [15:0] cur;
    logic [15:0] nxt;
  } ssi_dma_cnt_s;

endpackage

/* rtl/ssi_reset_sync.sv */
// Reset release synchroniser for the status bank.
// Assumes an active-low asynchronous reset; release is aligned to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module ssi_reset_sync (
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  output var  logic rst_n_o
);
  logic stage1_n;

  // Assert at once, release after two edges to avoid metastable recovery
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stage1_n <= 1'b0;
      rst_n_o  <= 1'b0;
    end
    else
    begin
      stage1_n <= 1'b1;
      rst_n_o  <= stage1_n;
    end
  end
endmodule
`default_nettype wire

/* rtl/ssi_flag_bank.sv */
// Bank of sticky flags, one per bit, where a set beats a clear.
// Assumes set and clear vectors are synchronous single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module ssi_flag_bank #(
  parameter int unsigned W = 12
) (
  input  wire logic         clk_sys_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] set_i,
  input  wire logic [W-1:0] clr_i,
  output var  logic [W-1:0] flags_o
);
  genvar g;
  // Set wins so an event landing on the clear cycle is never lost
  generate
    for (g = 0; g < W; g++)
    begin : g_flag
      always_ff @(posedge clk_sys_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          flags_o[g] <= 1'b0;
        else if (set_i[g])
          flags_o[g] <= 1'b1;
        else if (clr_i[g])
          flags_o[g] <= 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/ssi_status_irq.sv */
// Status flags, interrupt mask and APB register port of the serial controller.
// Assumes shift, holding and DMA logic outside deliver synchronous pulses and levels.
//
// Function
// [RULE1] Transmit buffers empty when both counters zero
// [RULE2] Receive ready while holding register full
// [RULE3] Overrun when word overwrites unread word
// [RULE4] Receive done at zero, cleared by counter write
// [RULE5] Receive buffers full when both counters zero
// [RULE6] Compare flags latch, clear on status read
// [RULE7] Frame-sync flags latch, clear on status read
// [RULE8] Bits 16/17 show transmitter, receiver enabled
// [RULE9] Enable register writes of one set mask
// [RULE10] Disable register writes of one clear mask
// [RULE11] Mask readback returns enabled sources
// [RULE12] Transmit ready low while word awaits shifter
// [RULE13] Transmit idle after last word fully shifted
// [RULE14] Transmit done at zero, cleared by counter write
// [RULE15] Interrupt when any enabled status bit set
// [RULE16] Reset clears every mask bit
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ssi_status_irq (
  input  wire logic                 clk_sys_i,
  input  wire logic                 nrst_i,
  // APB slave
  input  wire logic                 psel_i,
  input  wire logic                 penable_i,
  input  wire logic                 pwrite_i,
  input  wire logic [11:0]          paddr_i,
  input  wire logic [31:0]          pwdata_i,
  output var  logic [31:0]          prdata_o,
  output var  logic                 pready_o,
  output var  logic                 pslverr_o,
  // Transmit path
  input  wire logic                 tx_holding_write_i,
  input  wire logic                 tx_shift_load_i,
  input  wire logic                 tx_shift_done_i,
  input  wire logic                 transmitter_enabled_i,
  // Receive path
  input  wire logic                 rx_holding_load_i,
  input  wire logic                 rx_holding_read_i,
  input  wire logic                 receiver_enabled_i,
  // DMA counters and their software writes
  input  wire ssi_pkg::ssi_dma_cnt_s tx_dma_i,
  input  wire ssi_pkg::ssi_dma_cnt_s rx_dma_i,
  input  wire logic                 tx_counter_write_i,
  input  wire logic                 rx_counter_write_i,
  // Compare and frame-sync events
  input  wire ssi_pkg::ssi_events_s events_i,
  output var  logic                 irq_o
);

  logic        rst_n;
  logic        tx_holding_full;
  logic        tx_shifting;
  logic        rx_ready;
  logic        tx_cnt_was_zero;
  logic        rx_cnt_was_zero;
  logic        tx_cnt_zero;
  logic        rx_cnt_zero;
  logic [11:0] irq_mask;
  logic [11:0] sticky_set;
  logic [11:0] sticky_clr;
  logic [11:0] sticky;
  logic [31:0] status_word;
  logic [31:0] next_rdata;
  logic        next_err;
  logic        setup;
  logic        access_done;
  logic        wr_done;
  logic        rd_status_done;

  ssi_reset_sync u_rst (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .rst_n_o   (rst_n)
  );

  // Bus phase decode; one wait-free access cycle follows each setup
  assign setup          = psel_i && !penable_i;
  assign access_done    = psel_i && penable_i && pready_o;
  assign wr_done        = access_done && pwrite_i;
  assign rd_status_done = access_done && !pwrite_i && (paddr_i == ssi_pkg::OFF_STATUS);

  // Transmit holding register occupancy
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      tx_holding_full <= 1'b0;
    else if (tx_holding_write_i)
      tx_holding_full <= 1'b1; // [RULE12]
    else if (tx_shift_load_i)
      tx_holding_full <= 1'b0; // [RULE12]
  end

  // Shift register busy from load until its last bit has gone
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      tx_shifting <= 1'b0;
    else if (tx_shift_load_i)
      tx_shifting <= 1'b1; // [RULE13]
    else if (tx_shift_done_i)
      tx_shifting <= 1'b0; // [RULE13]
  end

  // Receive holding register occupancy; a new load beats a read
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      rx_ready <= 1'b0;
    else if (rx_holding_load_i)
      rx_ready <= 1'b1; // [RULE2]
    else if (rx_holding_read_i)
      rx_ready <= 1'b0; // [RULE2]
  end

  // Zero detection of the DMA counters
  assign tx_cnt_zero = (tx_dma_i.cur == 16'h0000);
  assign rx_cnt_zero = (rx_dma_i.cur == 16'h0000);

  // Previous zero state; starts at one so reset itself is not an arrival
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_cnt_was_zero <= 1'b1;
      rx_cnt_was_zero <= 1'b1;
    end
    else
    begin
      tx_cnt_was_zero <= tx_cnt_zero;
      rx_cnt_was_zero <= rx_cnt_zero;
    end
  end

  // Event sources of the sticky bits
  always_comb
  begin
    sticky_set = 12'h000;
    sticky_set[ssi_pkg::BIT_TX_DMA_DONE] = tx_cnt_zero && !tx_cnt_was_zero; // [RULE14]
    sticky_set[ssi_pkg::BIT_RX_DMA_DONE] = rx_cnt_zero && !rx_cnt_was_zero; // [RULE4]
    sticky_set[ssi_pkg::BIT_RX_OVERRUN]  = rx_holding_load_i && rx_ready
                                           && !rx_holding_read_i; // [RULE3]
    sticky_set[ssi_pkg::BIT_CMP_A]       = events_i.cmp_a; // [RULE6]
    sticky_set[ssi_pkg::BIT_CMP_B]       = events_i.cmp_b; // [RULE6]
    sticky_set[ssi_pkg::BIT_TX_SYNC]     = events_i.tx_sync; // [RULE7]
    sticky_set[ssi_pkg::BIT_RX_SYNC]     = events_i.rx_sync; // [RULE7]
  end

  // Clear sources; a status read only clears bits the reader actually saw
  always_comb
  begin
    sticky_clr = 12'h000;
    if (rd_status_done)
      sticky_clr = prdata_o[11:0] & ssi_pkg::READ_CLEAR_BITS; // [RULE6] [RULE7] [RULE3]
    if (wr_done && (paddr_i == ssi_pkg::OFF_EVT_CLEAR))
      sticky_clr = sticky_clr | (pwdata_i[11:0] & ssi_pkg::STICKY_BITS);
    sticky_clr[ssi_pkg::BIT_TX_DMA_DONE] = sticky_clr[ssi_pkg::BIT_TX_DMA_DONE]
                                           || tx_counter_write_i; // [RULE14]
    sticky_clr[ssi_pkg::BIT_RX_DMA_DONE] = sticky_clr[ssi_pkg::BIT_RX_DMA_DONE]
                                           || rx_counter_write_i; // [RULE4]
  end

  ssi_flag_bank #(
    .W (ssi_pkg::SRC_W)
  ) u_flags (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n),
    .set_i     (sticky_set),
    .clr_i     (sticky_clr),
    .flags_o   (sticky)
  );

  // Assembled status word; level bits are live, event bits come from the bank
  always_comb
  begin
    status_word = ssi_pkg::DATA_ZERO;
    status_word[11:0] = sticky & ssi_pkg::STICKY_BITS;
    status_word[ssi_pkg::BIT_TX_READY]    = !tx_holding_full; // [RULE12]
    status_word[ssi_pkg::BIT_TX_IDLE]     = !tx_holding_full && !tx_shifting; // [RULE13]
    status_word[ssi_pkg::BIT_TX_BUF_EMPT] = tx_cnt_zero
                                            && (tx_dma_i.nxt == 16'h0000); // [RULE1]
    status_word[ssi_pkg::BIT_RX_READY]    = rx_ready; // [RULE2]
    status_word[ssi_pkg::BIT_RX_BUF_FULL] = rx_cnt_zero
                                            && (rx_dma_i.nxt == 16'h0000); // [RULE5]
    status_word[ssi_pkg::BIT_TX_ENABLED]  = transmitter_enabled_i; // [RULE8]
    status_word[ssi_pkg::BIT_RX_ENABLED]  = receiver_enabled_i; // [RULE8]
  end

  // Interrupt mask: set and clear registers; set wins if both hit one bit
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask <= ssi_pkg::MASK_RESET; // [RULE16]
    else if (wr_done && (paddr_i == ssi_pkg::OFF_IRQ_SET))
      irq_mask <= irq_mask | pwdata_i[11:0]; // [RULE9]
    else if (wr_done && (paddr_i == ssi_pkg::OFF_IRQ_CLEAR))
      irq_mask <= irq_mask & ~pwdata_i[11:0]; // [RULE10]
  end

  // Read mux and error decode, evaluated in the setup cycle
  always_comb
  begin
    next_rdata = ssi_pkg::DATA_ZERO;
    next_err   = 1'b0;
    case (paddr_i)
      ssi_pkg::OFF_STATUS:
      begin
        next_rdata = status_word;
        next_err   = pwrite_i;
      end
      ssi_pkg::OFF_IRQ_MASK:
      begin
        next_rdata[11:0] = irq_mask; // [RULE11]
        next_err         = pwrite_i;
      end
      ssi_pkg::OFF_IRQ_SET, ssi_pkg::OFF_IRQ_CLEAR, ssi_pkg::OFF_EVT_CLEAR:
        next_err = !pwrite_i;
      default:
        next_err = 1'b1;
    endcase
  end

  // Registered answer; the snapshot taken at setup is what a read returns
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_o  <= ssi_pkg::DATA_ZERO;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else if (setup)
    begin
      prdata_o  <= pwrite_i ? ssi_pkg::DATA_ZERO : next_rdata;
      pready_o  <= 1'b1;
      pslverr_o <= next_err;
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // Interrupt line, registered so it leaves the block glitch-free
  always_ff @(posedge clk_sys_i or negedge rst_n)
  begin
    if (!rst_n)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_word[11:0] & irq_mask); // [RULE15]
  end

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  sequence s_setup_status;
    psel_i && !penable_i && !pwrite_i && (paddr_i == ssi_pkg::OFF_STATUS);
  endsequence

  sequence s_setup_mask;
    psel_i && !penable_i && !pwrite_i && (paddr_i == ssi_pkg::OFF_IRQ_MASK);
  endsequence

  AST_TX_BUF_EMPTY: assert property ( // [RULE1]
    s_setup_status |=> prdata_o[3] == ($past(tx_dma_i.cur) == 16'h0000
                                     && $past(tx_dma_i.nxt) == 16'h0000))
    else $error("transmit buffers empty flag wrong");

  AST_RX_READY: assert property ( // [RULE2]
    rx_holding_load_i |=> status_word[ssi_pkg::BIT_RX_READY] && rx_ready)
    else $error("receive ready not set after load");

  AST_OVERRUN: assert property ( // [RULE3]
    rx_holding_load_i && rx_ready && !rx_holding_read_i |=> sticky[5])
    else $error("overrun not flagged");

  AST_RX_DONE_CLR: assert property ( // [RULE4]
    rx_counter_write_i && !sticky_set[6] |=> !sticky[6])
    else $error("receive done not cleared by counter write");

  AST_RX_BUF_FULL: assert property ( // [RULE5]
    s_setup_status |=> prdata_o[7] == ($past(rx_dma_i.cur) == 16'h0000
                                     && $past(rx_dma_i.nxt) == 16'h0000))
    else $error("receive buffers full flag wrong");

  AST_CMP_READ_CLR: assert property ( // [RULE6]
    rd_status_done && prdata_o[8] && !events_i.cmp_a |=> !sticky[8])
    else $error("compare flag survived status read");

  AST_SYNC_LATCH: assert property ( // [RULE7]
    events_i.tx_sync ##1 (!rd_status_done
      && !(wr_done && paddr_i == ssi_pkg::OFF_EVT_CLEAR)) [*2] |-> sticky[10])
    else $error("transmit sync flag not held");

  AST_ENABLES: assert property ( // [RULE8]
    s_setup_status |=> prdata_o[17:16] == {$past(receiver_enabled_i),
                                           $past(transmitter_enabled_i)})
    else $error("enable bits wrong in status");

  AST_MASK_SET: assert property ( // [RULE9]
    wr_done && paddr_i == ssi_pkg::OFF_IRQ_SET |=> (irq_mask & $past(pwdata_i[11:0]))
                                                  == $past(pwdata_i[11:0]))
    else $error("enable write did not set mask");

  AST_MASK_CLR: assert property ( // [RULE10]
    wr_done && paddr_i == ssi_pkg::OFF_IRQ_CLEAR |=> (irq_mask & $past(pwdata_i[11:0]))
                                                    == 12'h000)
    else $error("disable write did not clear mask");

  AST_MASK_READ: assert property ( // [RULE11]
    s_setup_mask ##1 psel_i |-> prdata_o[11:0] == $past(irq_mask) && prdata_o[31:12] == 20'h00000)
    else $error("mask readback wrong");

  AST_TX_READY: assert property ( // [RULE12]
    tx_holding_write_i |=> !status_word[ssi_pkg::BIT_TX_READY])
    else $error("transmit ready not dropped");

  AST_TX_IDLE: assert property ( // [RULE13]
    tx_shift_load_i |=> !status_word[1])
    else $error("transmit idle during shifting");

  AST_TX_DONE: assert property ( // [RULE14]
    tx_cnt_zero && !tx_cnt_was_zero |=> sticky[2])
    else $error("transmit done not set at zero");

  AST_IRQ: assert property ( // [RULE15]
    |(status_word[11:0] & irq_mask) |=> irq_o)
    else $error("interrupt not raised for enabled source");

  AST_IRQ_LOW: assert property ( // [RULE15]
    !(|(status_word[11:0] & irq_mask)) |=> !irq_o)
    else $error("interrupt raised with no enabled source");

  AST_MASK_RESET: assert property ( // [RULE16]
    $rose(rst_n) |-> irq_mask == 12'h000)
    else $error("mask not cleared by reset");

endmodule
`default_nettype wire

/* dv/ssi_far_model.sv */
// Far-side model: serial datapath pulses, DMA counters and enable levels.
// Assumes the bench drives the request inputs just after a rising edge.
`timescale 1ns/1ps
`default_nettype none
module ssi_far_model (
  input  wire logic                  clk_sys_i,
  input  wire logic [10:0]           pulse_req_i,
  input  wire logic [1:0]            enables_req_i,
  input  wire ssi_pkg::ssi_dma_cnt_s tx_dma_req_i,
  input  wire ssi_pkg::ssi_dma_cnt_s rx_dma_req_i,
  output var  logic [10:0]           pulse_o,
  output var  logic [1:0]            enables_o,
  output var  ssi_pkg::ssi_dma_cnt_s tx_dma_o,
  output var  ssi_pkg::ssi_dma_cnt_s rx_dma_o
);
  // Every level and pulse leaves a flop, as the datapath and DMA engine do; costs one cycle
  always_ff @(posedge clk_sys_i)
  begin
    pulse_o   <= pulse_req_i;
    enables_o <= enables_req_i;
    tx_dma_o  <= tx_dma_req_i;
    rx_dma_o  <= rx_dma_req_i;
  end
endmodule
`default_nettype wire

/* dv/ssi_status_irq_tb_top.sv */
// Self-checking bench for the serial status and interrupt bank.
// Assumes the far-side model in ssi_far_model and an APB master in tasks.
`timescale 1ns/1ps
`default_nettype none
module ssi_status_irq_tb_top;
  logic                  clk_sys_i = 1'b0;
  logic                  nrst_i    = 1'b0;
  logic                  psel      = 1'b0;
  logic                  penable   = 1'b0;
  logic                  pwrite    = 1'b0;
  logic [11:0]           paddr     = 12'h000;
  logic [31:0]           pwdata    = 32'h0000_0000;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  irq;
  logic [10:0]           pulse;
  logic [1:0]            en;
  ssi_pkg::ssi_dma_cnt_s tx_dma;
  ssi_pkg::ssi_dma_cnt_s rx_dma;
  logic [10:0]           pulse_req  = 11'h000;
  logic [1:0]            en_req     = 2'h0;
  ssi_pkg::ssi_dma_cnt_s tx_req     = 32'h0001_0001; // Nonzero: buffer flags start low
  ssi_pkg::ssi_dma_cnt_s rx_req     = 32'h0001_0001;
  int                    n_mismatch = 0;
  int                    n_compared = 0;

  // 100 MHz system clock
  always #5 clk_sys_i = ~clk_sys_i;

  ssi_far_model i_ssi_far_model (
    .clk_sys_i     (clk_sys_i),
    .pulse_req_i   (pulse_req),
    .enables_req_i (en_req),
    .tx_dma_req_i  (tx_req),
    .rx_dma_req_i  (rx_req),
    .pulse_o   (pulse),
    .enables_o (en),
    .tx_dma_o  (tx_dma),
    .rx_dma_o  (rx_dma)
  );

  ssi_status_irq i_ssi_status_irq (
    .clk_sys_i             (clk_sys_i),
    .nrst_i                (nrst_i),
    .psel_i                (psel),
    .penable_i             (penable),
    .pwrite_i              (pwrite),
    .paddr_i               (paddr),
    .pwdata_i              (pwdata),
    .prdata_o              (prdata),
    .pready_o              (pready),
    .pslverr_o             (pslverr),
    .tx_holding_write_i    (pulse[0]),
    .tx_shift_load_i       (pulse[1]),
    .tx_shift_done_i       (pulse[2]),
    .transmitter_enabled_i (en[0]),
    .rx_holding_load_i     (pulse[3]),
    .rx_holding_read_i     (pulse[4]),
    .receiver_enabled_i    (en[1]),
    .tx_dma_i              (tx_dma),
    .rx_dma_i              (rx_dma),
    .tx_counter_write_i    (pulse[5]),
    .rx_counter_write_i    (pulse[6]),
    .events_i              (ssi_pkg::ssi_events_s'(pulse[10:7])),
    .irq_o                 (irq)
  );

  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // APB transfer; only the watchdog ends a wait on a hung slave
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk_sys_i);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys_i);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    chk(nm, q, exp);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // One-cycle pulse request; the model forwards it one edge later
  task automatic fire(input logic [10:0] m);
    @(posedge clk_sys_i);
    pulse_req <= m;
    @(posedge clk_sys_i);
    pulse_req <= 11'h000;
  endtask

  // Counter levels move just after an edge, as the DMA engine does
  task automatic set_cnt(input logic [15:0] tc, input logic [15:0] tn,
                         input logic [15:0] rc, input logic [15:0] rn);
    @(posedge clk_sys_i);
    tx_req <= {tc, tn};
    rx_req <= {rc, rn};
  endtask

  task automatic set_en(input logic [1:0] e);
    @(posedge clk_sys_i);
    en_req <= e;
  endtask

  // Reset values and refused accesses
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd("status", 12'h000, 32'h0000_0003);
    rd("mask", 12'h00C, 32'h0000_0000);
    apb(1'b0, 12'h014, 32'h0000_0000, q, e);
    chk("unmapped err", {31'h0, e}, 32'h0000_0001);
    apb(1'b1, 12'h000, 32'hFFFF_FFFF, q, e);
    chk("ro write err", {31'h0, e}, 32'h0000_0001);
    $display("test reset done");
  endtask

  // Set, no-effect zero, partial clear, full clear
  task automatic t_mask();
    wr(12'h004, 32'hFFFF_FFFF);
    rd("mask", 12'h00C, 32'h0000_0FFF);
    wr(12'h004, 32'h0000_0000);
    rd("mask", 12'h00C, 32'h0000_0FFF);
    wr(12'h008, 32'h0000_00F0);
    rd("mask", 12'h00C, 32'h0000_0F0F);
    wr(12'h008, 32'h0000_0000);
    rd("mask", 12'h00C, 32'h0000_0F0F);
    wr(12'h008, 32'h0000_0FFF);
    rd("mask", 12'h00C, 32'h0000_0000);
    $display("test mask done");
  endtask

  // Transmit word written, loaded, shifted out
  task automatic t_tx();
    fire(11'h001);
    rd("tx written", 12'h000, 32'h0000_0000);
    fire(11'h002);
    rd("tx loaded", 12'h000, 32'h0000_0001);
    fire(11'h004);
    rd("tx shifted", 12'h000, 32'h0000_0003);
    $display("test tx done");
  endtask

  // Receive word, overwrite before read, read clears overrun only
  task automatic t_rx();
    fire(11'h008);
    rd("rx ready", 12'h000, 32'h0000_0013);
    fire(11'h008);
    rd("rx overrun", 12'h000, 32'h0000_0033);
    rd("rx after read", 12'h000, 32'h0000_0013);
    fire(11'h010);
    rd("rx emptied", 12'h000, 32'h0000_0003);
    $display("test rx done");
  endtask

  // Counters reaching zero, buffer flags, clear by counter write
  task automatic t_dma();
    set_cnt(16'h0000, 16'h0001, 16'h0001, 16'h0001);
    cyc(3);
    rd("tx done", 12'h000, 32'h0000_0007);
    set_cnt(16'h0000, 16'h0000, 16'h0001, 16'h0001);
    cyc(3);
    rd("tx empty", 12'h000, 32'h0000_000F);
    fire(11'h020);
    rd("tx cnt wr", 12'h000, 32'h0000_000B);
    set_cnt(16'h0001, 16'h0001, 16'h0000, 16'h0001);
    cyc(3);
    rd("rx done", 12'h000, 32'h0000_0043);
    set_cnt(16'h0001, 16'h0001, 16'h0000, 16'h0000);
    cyc(3);
    rd("rx full", 12'h000, 32'h0000_00C3);
    fire(11'h040);
    rd("rx cnt wr", 12'h000, 32'h0000_0083);
    set_cnt(16'h0001, 16'h0001, 16'h0001, 16'h0001);
    cyc(3);
    rd("dma idle", 12'h000, 32'h0000_0003);
    $display("test dma done");
  endtask

  // Each compare and sync event latches, read clears; enables are live
  task automatic t_events();
    for (int i = 0; i < 4; i++)
    begin
      fire(11'h080 << i);
      rd("event set", 12'h000, 32'h0000_0003 | (32'h0000_0100 << i));
      rd("event clr", 12'h000, 32'h0000_0003);
    end
    // Sync flag held with no read, then dropped by the event clear register
    fire(11'h200);
    cyc(2);
    wr(12'h010, 32'h0000_0400);
    rd("sync evt clr", 12'h000, 32'h0000_0003);
    set_en(2'h3);
    rd("enables", 12'h000, 32'h0003_0003);
    set_en(2'h2);
    rd("rx enable", 12'h000, 32'h0002_0003);
    set_en(2'h0);
    $display("test events done");
  endtask

  // Enabled source raises the line, read drops it, a masked source leaves it low
  task automatic t_irq();
    chk("irq idle", {31'h0, irq}, 32'h0000_0000);
    wr(12'h004, 32'h0000_0100);
    fire(11'h080);
    cyc(3);
    chk("irq on", {31'h0, irq}, 32'h0000_0001);
    rd("irq src", 12'h000, 32'h0000_0103);
    cyc(3);
    chk("irq after read", {31'h0, irq}, 32'h0000_0000);
    wr(12'h008, 32'h0000_0100);
    fire(11'h080);
    cyc(3);
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    rd("masked src", 12'h000, 32'h0000_0103);
    $display("test irq done");
  endtask

  // Watchdog sized far above the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    n_mismatch++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    t_reset();
    t_mask();
    t_tx();
    t_rx();
    t_dma();
    t_events();
    t_irq();
    results();
  end
endmodule
`default_nettype wire
